//--- inc/cucfg_pkg.sv
// Constants and carriers for the customer configuration register block.
// Assumes a 32-bit classic Wishbone slave port and a flash load engine outside.
//
// Behaviour
// (R1) Every writable field stays locked until the key field is written 01, then 10, then 11.
// (R2) With the key at 11, writable fields take any write until the key is cleared.
// (R3) With the key at 11, only a write of 00 clears it; other values are ignored and 11 stays.
// (R4) Writes to read-only or locked bits change nothing and still end with a normal ack.
// (R5) The program-block flag loads 0 from an erased area, 1 on a match; 1 blocks page program.
// (R6) The erase-block flag loads 0 from an erased area, 1 on a match; 1 blocks page erase.
// (R7) Crystal-off loads 1 erased, 0 matched, is writable, and moves the crystal pins to port lines.
// (R8) Crystal-bypass loads 0 erased, 1 matched, is writable, and turns the input into a clock input; the code does so only while crystal-off is 0.
// (R9) Debug-off loads 0 erased, 1 matched, and moves the debug pins to port and analog lines.
// (R10) Clock-output-off loads 1 erased, 0 matched, is writable, and moves that pin to a port line.
// (R11) Reset-output-off loads 1 erased, 0 matched, is writable, and moves that pin to port-one line 6.
// (R12) Clock source select loads 1 erased, 0 matched; 1 picks the internal RC, 0 the external one.
// (R13) Serial-download-off loads 0 erased, 1 matched; 1 disables the serial download bus.
// (R14) The ADC power-on setting loads 0 erased, 1 matched and tells whether ADC defaults load.
// (R15) Only supervisor accesses reach the register; a user access changes nothing and errors.
// (R16) The key resets to 00 with the tracker idle; an out-of-order write restarts the tracker.
// (R17) Protection, debug, clock source, download and ADC fields stay read-only when unlocked.

package cucfg_pkg;

  localparam logic [7:0] CUSTOMER_CONFIGURATION_OFS = 8'h1C;
  localparam int HALF_POS = 16;
  localparam int KEY_POS = 0;
  localparam int FIELD_POS = 2;

  localparam logic [1:0] KEY_CLEAR = 2'h0;
  localparam logic [1:0] KEY_STEP1 = 2'h1;
  localparam logic [1:0] KEY_STEP2 = 2'h2;
  localparam logic [1:0] KEY_OPEN = 2'h3;

  // Field order matches register bits 11 down to 2
  typedef struct packed {
    logic adc_poweron_setting;
    logic serial_download_off;
    logic clock_source_select;
    logic reset_output_off;
    logic clock_output_off;
    logic debug_port_off;
    logic crystal_bypass;
    logic crystal_off;
    logic info_area_erase_block;
    logic info_area_program_block;
  } cucfg_fields_t;

  localparam logic [9:0] FIELDS_ERASED = 10'h0E4;
  localparam logic [9:0] FIELDS_MATCHED = 10'h31B;
  localparam logic [9:0] FIELDS_WRITABLE = 10'h06C;

  // Pin function switches, 1 = pin handed to the alternate function
  typedef struct packed {
    logic crystal_input_pin_as_port_zero_line2;
    logic crystal_output_pin_as_port_one_line7;
    logic crystal_input_pin_as_clock_input;
    logic debug_clock_pin_as_port_zero_line0;
    logic debug_data_pin_as_analog_input_line2;
    logic clock_output_pin_as_port_one_line0;
    logic reset_output_pin_as_port_one_line6;
    logic internal_rc_oscillator_selected;
  } cucfg_pins_t;

  typedef enum logic [3:0] {
    KEY_ST_IDLE = 4'h1,
    KEY_ST_ONE = 4'h2,
    KEY_ST_TWO = 4'h4,
    KEY_ST_OPEN = 4'h8
  } cucfg_key_state_t;

endpackage

//--- rtl/cucfg_unlock.sv
// Unlock key tracker for the customer configuration register.
// Assumes key_wr_i is a one-cycle strobe from an accepted supervisor write.
`timescale 1ns/1ps
`default_nettype none

module cucfg_unlock (
  input wire logic clk_i,        // System clock
  input wire logic rst_i,        // Synchronous reset, active high
  input wire logic key_wr_i,     // Key field write strobe
  input wire logic [1:0] key_i,  // Value written to the key field
  output logic [1:0] key_o,      // Key field read back
  output logic open_o            // Writable fields unlocked
);

  cucfg_pkg::cucfg_key_state_t state_r;
  cucfg_pkg::cucfg_key_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    if (key_wr_i)
    begin
      case (state_r)
        cucfg_pkg::KEY_ST_OPEN:
        begin
          if (key_i == cucfg_pkg::KEY_CLEAR) // R3
            state_nxt = cucfg_pkg::KEY_ST_IDLE;
        end
        cucfg_pkg::KEY_ST_ONE:
        begin
          if (key_i == cucfg_pkg::KEY_STEP2) // R1
            state_nxt = cucfg_pkg::KEY_ST_TWO;
          else if (key_i == cucfg_pkg::KEY_STEP1)
            state_nxt = cucfg_pkg::KEY_ST_ONE;
          else
            state_nxt = cucfg_pkg::KEY_ST_IDLE; // R16
        end
        cucfg_pkg::KEY_ST_TWO:
        begin
          if (key_i == cucfg_pkg::KEY_OPEN) // R1
            state_nxt = cucfg_pkg::KEY_ST_OPEN;
          else if (key_i == cucfg_pkg::KEY_STEP1)
            state_nxt = cucfg_pkg::KEY_ST_ONE;
          else
            state_nxt = cucfg_pkg::KEY_ST_IDLE; // R16
        end
        default:
        begin
          if (key_i == cucfg_pkg::KEY_STEP1) // R1
            state_nxt = cucfg_pkg::KEY_ST_ONE;
          else
            state_nxt = cucfg_pkg::KEY_ST_IDLE; // R16
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= cucfg_pkg::KEY_ST_IDLE; // R16
    else
      state_r <= state_nxt;
  end

  // Read back: 11 only when open, an early 11 shows as 00
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_o <= cucfg_pkg::KEY_CLEAR; // R16
    else if (key_wr_i && state_r != cucfg_pkg::KEY_ST_OPEN)
      key_o <= (state_nxt == cucfg_pkg::KEY_ST_OPEN || key_i != cucfg_pkg::KEY_OPEN) ?
               key_i : cucfg_pkg::KEY_CLEAR;
    else if (key_wr_i && key_i == cucfg_pkg::KEY_CLEAR)
      key_o <= cucfg_pkg::KEY_CLEAR; // R3
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      open_o <= 1'b0;
    else
      open_o <= (state_nxt == cucfg_pkg::KEY_ST_OPEN); // R2
  end

endmodule // cucfg_unlock

`default_nettype wire

//--- rtl/cucfg_top.sv
// Customer configuration register with key-protected writes and pin routing.
// Assumes a classic Wishbone master, a supervisor tag per access and a
// flash load engine that pulses load_i once after power-on.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module cucfg_top (
  input wire logic clk_i,                        // System clock, 20 MHz
  input wire logic rst_i,                        // Synchronous reset, active high
  input wire logic cyc_i,                        // Wishbone cycle
  input wire logic stb_i,                        // Wishbone strobe
  input wire logic we_i,                         // Wishbone write enable
  input wire logic [7:0] adr_i,                  // Wishbone byte address
  input wire logic [3:0] sel_i,                  // Wishbone byte selects
  input wire logic [31:0] dat_i,                 // Wishbone write data
  input wire logic supervisor_i,                 // Access made in supervisor mode
  input wire logic load_i,                       // Power-on load strobe
  input wire cucfg_pkg::cucfg_fields_t load_match_i, // Per field: 1 matched, 0 erased
  output logic [31:0] dat_o,                     // Wishbone read data
  output logic ack_o,                            // Wishbone acknowledge
  output logic err_o,                            // Wishbone error
  output cucfg_pkg::cucfg_fields_t fields_o,     // Current field values
  output cucfg_pkg::cucfg_pins_t pins_o,         // Pin function switches
  output logic unlocked_o                        // Writable fields open
);

  cucfg_pkg::cucfg_fields_t fields_r;
  cucfg_pkg::cucfg_fields_t load_val;
  cucfg_pkg::cucfg_fields_t write_val;
  logic [1:0] key_val;
  logic key_open;
  logic req;
  logic hit;
  logic user_req;
  logic wr_ok;
  logic rd_ok;
  logic key_wr;
  logic hi_lo_wr;
  logic hi_hi_wr;
  logic [15:0] half_wr;
  logic [15:0] half_rd;
  logic [9:0] wr_mask;

  // New request, one answer per request
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit = (adr_i[7:2] == cucfg_pkg::CUSTOMER_CONFIGURATION_OFS[7:2]);
  assign user_req = req && !supervisor_i; // R15
  assign wr_ok = req && supervisor_i && we_i && hit;
  assign rd_ok = req && supervisor_i && !we_i;

  assign half_wr = dat_i[31:16];
  assign hi_lo_wr = wr_ok && sel_i[2];
  assign hi_hi_wr = wr_ok && sel_i[3];
  assign key_wr = hi_lo_wr;

  // Erased or matched value for each field at power-on load
  assign load_val = (load_match_i & cucfg_pkg::FIELDS_MATCHED) |
                    (~load_match_i & cucfg_pkg::FIELDS_ERASED); // R5 R6 R7 R8 R9 R10 R11 R12 R13 R14

  // Writable bits covered by the enabled byte lanes
  always_comb
  begin
    wr_mask = cucfg_pkg::FIELDS_WRITABLE; // R17
    if (!hi_lo_wr)
      wr_mask[5:0] = 6'h00;
    if (!hi_hi_wr)
      wr_mask[9:6] = 4'h0;
    if (!key_open)
      wr_mask = 10'h000; // R1 R4
  end

  assign write_val = (fields_r & ~wr_mask) |
                     (half_wr[cucfg_pkg::FIELD_POS +: 10] & wr_mask); // R2 R4

  cucfg_unlock u_unlock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .key_wr_i(key_wr),
    .key_i(half_wr[cucfg_pkg::KEY_POS +: 2]),
    .key_o(key_val),
    .open_o(key_open)
  );

  // Field storage: reset to erased values, load wins over a bus write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fields_r <= cucfg_pkg::FIELDS_ERASED;
    else if (load_i)
      fields_r <= load_val;
    else if (wr_ok)
      fields_r <= write_val;
  end

  assign half_rd = {4'h0, fields_r, key_val};

  // Bus answer: one cycle after the request, error for user mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req && supervisor_i; // R4
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      err_o <= 1'b0;
    else
      err_o <= user_req; // R15
  end

  // Low half and other words read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (rd_ok && hit)
      dat_o <= {half_rd, 16'h0000};
    else if (req)
      dat_o <= 32'h0000_0000;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fields_o <= cucfg_pkg::FIELDS_ERASED;
    else
      fields_o <= fields_r;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      unlocked_o <= 1'b0;
    else
      unlocked_o <= key_open;
  end

  // Pin routing follows the fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pins_o <= '0;
    end
    else
    begin
      pins_o.crystal_input_pin_as_port_zero_line2 <= fields_r.crystal_off; // R7
      pins_o.crystal_output_pin_as_port_one_line7 <=
        fields_r.crystal_off || fields_r.crystal_bypass; // R7 R8
      pins_o.crystal_input_pin_as_clock_input <=
        fields_r.crystal_bypass && !fields_r.crystal_off; // R8
      pins_o.debug_clock_pin_as_port_zero_line0 <= fields_r.debug_port_off; // R9
      pins_o.debug_data_pin_as_analog_input_line2 <= fields_r.debug_port_off; // R9
      pins_o.clock_output_pin_as_port_one_line0 <= fields_r.clock_output_off; // R10
      pins_o.reset_output_pin_as_port_one_line6 <= fields_r.reset_output_off; // R11
      pins_o.internal_rc_oscillator_selected <= fields_r.clock_source_select; // R12
    end
  end

endmodule // cucfg_top

`default_nettype wire

//--- test/cucfg_sva.sv
// Port checker for the customer configuration register.
// Assumes a bind onto cucfg_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none

module cucfg_sva (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write
  input wire logic [7:0] adr_i, // Address
  input wire logic [3:0] sel_i, // Selects
  input wire logic [31:0] dat_i, // Write data
  input wire logic supervisor_i, // Supervisor
  input wire logic load_i, // Load strobe
  input wire cucfg_pkg::cucfg_fields_t load_match_i, // Match flags
  input wire logic [31:0] dat_o, // Read data
  input wire logic ack_o, // Ack
  input wire logic err_o, // Error
  input wire cucfg_pkg::cucfg_fields_t fields_o, // Fields
  input wire cucfg_pkg::cucfg_pins_t pins_o, // Pins
  input wire logic unlocked_o // Open
);
  logic take, wr0, wr;
  logic [9:0] f, load_exp_r;
  logic [7:0] pin_exp;
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  assign wr0 = take && we_i && supervisor_i;
  assign wr = wr0 && !load_i;
  assign f = fields_o;
  assign pin_exp = {f[2], f[2] | f[3], f[3] & ~f[2], f[4], f[4], f[5], f[6], f[7]};
  always_ff @(posedge clk_i)
  begin
    if (load_i)
      load_exp_r <= (load_match_i & cucfg_pkg::FIELDS_MATCHED) |
        (~load_match_i & cucfg_pkg::FIELDS_ERASED);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (take && supervisor_i |=> ack_o && !err_o)
    else $error("no ack after supervisor access");
  a_err_user: assert property (take && !supervisor_i |=> err_o && !ack_o)
    else $error("no error after user access");
  a_user_none: assert property (take && !supervisor_i && !load_i && !$past(load_i) |=>
    ##1 ($stable(fields_o) && $stable(unlocked_o)))
    else $error("user access changed state");
  a_locked_hold: assert property (wr && !unlocked_o && !$past(load_i) |=> ##1 $stable(fields_o))
    else $error("locked write changed fields");
  a_readonly_hold: assert property (wr && !$past(load_i) |=>
    ##1 $stable(fields_o & ~cucfg_pkg::FIELDS_WRITABLE))
    else $error("read-only field changed");
  a_load_value: assert property (load_i ##1 !load_i |=> fields_o == load_exp_r)
    else $error("loaded fields wrong");
  a_pins_map: assert property (!$past(rst_i) |-> pins_o == pin_exp)
    else $error("pin switches do not follow fields");
  a_open_key: assert property ($rose(unlocked_o) |->
    $past(wr0 && sel_i[2] && dat_i[17:16] == cucfg_pkg::KEY_OPEN, 2))
    else $error("opened without final key step");
  a_open_stays: assert property (unlocked_o && wr0 && sel_i[2] && adr_i[7:2] == 6'h07 &&
    dat_i[17:16] != cucfg_pkg::KEY_CLEAR |=> ##1 unlocked_o)
    else $error("open key lost on non-zero write");
  a_unmapped_zero: assert property (take && !we_i && supervisor_i && adr_i[7:2] != 6'h07 |=>
    dat_o == 32'h0)
    else $error("unmapped word read non-zero");
  c_open: cover property ($rose(unlocked_o));
  c_relock: cover property ($fell(unlocked_o));
  c_open_write: cover property (wr && unlocked_o);
  c_user: cover property (err_o);
endmodule // cucfg_sva

`default_nettype wire

//--- test/cucfg_bench.sv
// Self-checking bench for the customer configuration register.
// Assumes the package, cucfg_top and cucfg_sva are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module cucfg_bench;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, supervisor_i, load_i, ack_o, err_o, unlocked_o, e;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [9:0] ef;
  cucfg_pkg::cucfg_fields_t load_match_i, fields_o;
  cucfg_pkg::cucfg_pins_t pins_o;
  int err_count, checks_done;

  cucfg_top i_cucfg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .supervisor_i(supervisor_i),
    .load_i(load_i), .load_match_i(load_match_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .fields_o(fields_o), .pins_o(pins_o), .unlocked_o(unlocked_o));

  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic s);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, supervisor_i} <= {2'h3, w, s};
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
    if (n >= 20)
      err_count++;
    rd = dat_o;
    e = err_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask

  task automatic wreg(input logic [1:0] k, input logic [9:0] f);
    wb(1'h1, 8'h1C, {4'h0, f, k, 16'h0}, 1'h1);
    chk("write err", {31'h0, e}, 32'h0);
  endtask

  task automatic rchk(input string n, input logic [1:0] k);
    wb(1'h0, 8'h1C, 32'h0, 1'h1);
    chk(n, rd, {4'h0, ef, k, 16'h0});
    chk("fields", {22'h0, fields_o}, {22'h0, ef});
  endtask

  task automatic t_load(input logic [9:0] m);
    @(posedge clk_i);
    load_match_i <= m;
    load_i <= 1'h1;
    @(posedge clk_i);
    load_i <= 1'h0;
    ef = (m & cucfg_pkg::FIELDS_MATCHED) | (~m & cucfg_pkg::FIELDS_ERASED);
    rchk("load", 2'h0);
  endtask

  task automatic t_locked();
    wreg(2'h0, 10'h3FF);
    rchk("locked", 2'h0);
    wreg(2'h1, 10'h3FF);
    wreg(2'h3, 10'h3FF);
    rchk("bad order", 2'h0);
    chk("open", {31'h0, unlocked_o}, 32'h0);
  endtask

  task automatic t_unlock();
    wreg(2'h1, 10'h000);
    wreg(2'h2, 10'h000);
    wreg(2'h3, 10'h3FF);
    rchk("opened", 2'h3);
    chk("open", {31'h0, unlocked_o}, 32'h1);
    wreg(2'h2, 10'h000);
    ef = ef & ~cucfg_pkg::FIELDS_WRITABLE;
    rchk("open clear", 2'h3);
    wreg(2'h1, 10'h3FF);
    ef = ef | cucfg_pkg::FIELDS_WRITABLE;
    rchk("open set", 2'h3);
    wreg(2'h0, 10'h000);
    ef = ef & ~cucfg_pkg::FIELDS_WRITABLE;
    rchk("relock", 2'h0);
    chk("open", {31'h0, unlocked_o}, 32'h0);
  endtask

  task automatic t_other();
    wb(1'h1, 8'h1C, 32'hFFFFFFFF, 1'h0);
    chk("user err", {31'h0, e}, 32'h1);
    rchk("user", 2'h0);
    wb(1'h1, 8'h20, 32'hFFFFFFFF, 1'h1);
    wb(1'h0, 8'h20, 32'h0, 1'h1);
    chk("unmapped", rd, 32'h0);
    rchk("unmapped", 2'h0);
  endtask

  initial
  begin
    {err_count, checks_done} = {32'h0, 32'h0};
    {rst_i, cyc_i, stb_i, we_i, supervisor_i, load_i} = 6'h20;
    {adr_i, sel_i, dat_i} = {8'h0, 4'hF, 32'h0};
    load_match_i = 10'h000;
    ef = cucfg_pkg::FIELDS_ERASED;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rchk("reset", 2'h0);
    t_load(10'h155);
    t_load(10'h3FF);
    t_load(10'h000);
    t_locked();
    t_unlock();
    t_other();
    stop_test();
  end

  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule // cucfg_bench

bind cucfg_top cucfg_sva i_cucfg_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .supervisor_i(supervisor_i), .load_i(load_i), .load_match_i(load_match_i), .dat_o(dat_o),
  .ack_o(ack_o), .err_o(err_o), .fields_o(fields_o), .pins_o(pins_o), .unlocked_o(unlocked_o));

`default_nettype wire
